// >>> shared/dam_map.vh
`ifndef DAM_MAP_VH
`define DAM_MAP_VH
// Register addresses (even byte address of each 16-bit register)
`define DAM_ADDR_THRESH1   7'h26
`define DAM_ADDR_THRESH2   7'h28
`define DAM_ADDR_COUNT1    7'h2a
`define DAM_ADDR_COUNT2    7'h2c
`define DAM_ADDR_CTRL      7'h2e
`define DAM_ADDR_STATUS    7'h3c
// Reset values
`define DAM_RST_THRESH     16'h0000
`define DAM_RST_COUNT      16'h0000
`define DAM_RST_CTRL       16'h0000
// Control field positions
`define DAM_SRC2_HI        15
`define DAM_SRC2_LO        12
`define DAM_SRC1_HI        11
`define DAM_SRC1_LO        8
`define DAM_SLOPE2_BIT     7
`define DAM_SLOPE1_BIT     6
`define DAM_FILT_BIT       4
`define DAM_OUT_EN_BIT     2
`define DAM_OUT_POL_BIT    1
`define DAM_OUT_SEL_BIT    0
// Threshold fields
`define DAM_DIR_BIT        15
`define DAM_MAG_HI         13
// Status fields
`define DAM_STAT_ALM2_BIT  9
`define DAM_STAT_ALM1_BIT  8
// Source codes
`define DAM_SRC_OFF        4'h0
`define DAM_SRC_MAX        4'hb
`define DAM_NUM_SRC        12
`endif

// >>> src/dam_alarm_unit.v
`timescale 1ns/1ps
`include "dam_map.vh"
module dam_alarm_unit #(
    parameter DW = 14
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          sample_en,
    input  wire [3:0]    src_sel,
    input  wire          slope_mode,
    input  wire [15:0]   threshold,
    input  wire [7:0]    sample_count,
    input  wire [DW-1:0] sample,
    output reg           active
);
    localparam AW = DW + 9;
    reg  signed [DW-1:0] prev;
    reg                  have_prev;
    reg  signed [AW-1:0] acc;
    reg  [7:0]           cnt;
    reg  signed [AW-1:0] avg;
    reg                  avg_valid;
    wire signed [DW-1:0] thr = threshold[`DAM_MAG_HI:0];
    wire signed [AW-1:0] delta = $signed(sample) - prev; // see (RULE_10)
    wire [7:0]           n = (sample_count == 8'h00) ? 8'h01 : sample_count;
    wire signed [AW-1:0] sum_now = acc + delta;
    wire signed [AW-1:0] avg_now = sum_now / $signed({{(AW-8){1'b0}}, n}); // see (RULE_10)
    // A window closing on this sample is compared at once, not one sample late
    wire                 win_done = slope_mode && have_prev && (cnt + 8'h01 >= n);
    wire signed [AW-1:0] val = slope_mode ? (win_done ? avg_now : avg)
                                          : {{(AW-DW){sample[DW-1]}}, sample};
    wire                 enabled = (src_sel != `DAM_SRC_OFF) && (src_sel <= `DAM_SRC_MAX);
    wire                 hit = threshold[`DAM_DIR_BIT] ? (val > thr) : (val < thr); // see (RULE_09)
    wire                 ready = slope_mode ? (win_done || avg_valid) : 1'b1;
    always @(posedge clk) begin
        if (!rst_n || !enabled) begin
            prev      <= {DW{1'b0}};
            have_prev <= 1'b0;
            acc       <= {AW{1'b0}};
            cnt       <= 8'h00;
            avg       <= {AW{1'b0}};
            avg_valid <= 1'b0;
            active    <= 1'b0; // see (RULE_12)
        end else if (sample_en) begin
            prev      <= sample;
            have_prev <= 1'b1;
            if (slope_mode && have_prev) begin
                // Averaging by division; window length is host-programmed
                if (win_done) begin
                    avg       <= avg_now; // see (RULE_10)
                    avg_valid <= 1'b1;
                    acc       <= {AW{1'b0}};
                    cnt       <= 8'h00;
                end else begin
                    acc <= sum_now;
                    cnt <= cnt + 8'h01;
                end
            end
            active <= ready && hit;
        end
    end
endmodule // dam_alarm_unit

// >>> src/dam_top.v
// Operation
// (RULE_01) Bits 15:12 pick second alarm source; 0 off, 1..11 supply, gyros, accels, temps, aux.
// (RULE_02) Bits 11:8 pick first alarm source with the same encoding.
// (RULE_03) Bit 7 selects slope compare for second alarm, else static level.
// (RULE_04) Bit 6 selects slope compare for first alarm, else static level.
// (RULE_05) Bit 4 feeds filtered data to both comparators, else unfiltered.
// (RULE_06) Bit 2 enables driving the alarm onto a general line.
// (RULE_07) Bit 1 sets output polarity: 1 active high, 0 active low.
// (RULE_08) Bit 0 selects second general line when 1, first when 0.
// (RULE_09) Threshold bit 15 is direction (1 greater), bits 13:0 magnitude.
// (RULE_10) Slope mode averages sample deltas over the count, then compares.
// (RULE_11) Status bit 9 shows second alarm, bit 8 first alarm.
// (RULE_12) Alarm with source zero never asserts and contributes nothing.
// (RULE_13) Enabled line shows OR of both alarms at programmed polarity.
`timescale 1ns/1ps
`include "dam_map.vh"
module dam_top #(
    parameter DW = 14
) (
    input  wire                   clk,
    input  wire                   rst_n,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    input  wire [6:0]             reg_addr,
    input  wire [15:0]            reg_wdata,
    output reg  [15:0]            reg_rdata,
    input  wire                   sample_en,
    input  wire [12*DW-1:0]       raw_data,
    input  wire [12*DW-1:0]       filt_data,
    output reg                    first_general_line,
    output reg                    first_general_line_oe_n,
    output reg                    second_general_line,
    output reg                    second_general_line_oe_n,
    output reg  [1:0]             alarm_status
);
    reg  [15:0] first_alarm_threshold;
    reg  [15:0] second_alarm_threshold;
    reg  [15:0] first_alarm_sample_count;
    reg  [15:0] second_alarm_sample_count;
    reg  [15:0] alarm_control;
    wire        act1;
    wire        act2;

    function [DW-1:0] pick;
        input [3:0]         sel;
        input [12*DW-1:0]   bus;
        begin
            pick = bus[sel*DW +: DW];
        end
    endfunction

    wire [12*DW-1:0] src_bus = alarm_control[`DAM_FILT_BIT] ? filt_data : raw_data; // see (RULE_05)
    wire [DW-1:0] samp1 = pick(alarm_control[`DAM_SRC1_HI:`DAM_SRC1_LO], src_bus); // see (RULE_02)
    wire [DW-1:0] samp2 = pick(alarm_control[`DAM_SRC2_HI:`DAM_SRC2_LO], src_bus); // see (RULE_01)

    always @(posedge clk) begin
        if (!rst_n) begin
            first_alarm_threshold     <= `DAM_RST_THRESH;
            second_alarm_threshold    <= `DAM_RST_THRESH;
            first_alarm_sample_count  <= `DAM_RST_COUNT;
            second_alarm_sample_count <= `DAM_RST_COUNT;
            alarm_control             <= `DAM_RST_CTRL;
        end else if (reg_wr) begin
            case (reg_addr)
                `DAM_ADDR_THRESH1: first_alarm_threshold     <= reg_wdata & 16'hbfff;
                `DAM_ADDR_THRESH2: second_alarm_threshold    <= reg_wdata & 16'hbfff;
                `DAM_ADDR_COUNT1:  first_alarm_sample_count  <= {8'h00, reg_wdata[7:0]};
                `DAM_ADDR_COUNT2:  second_alarm_sample_count <= {8'h00, reg_wdata[7:0]};
                `DAM_ADDR_CTRL:    alarm_control             <= reg_wdata & 16'hffd7;
                default: begin
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `DAM_ADDR_THRESH1: reg_rdata <= first_alarm_threshold;
                `DAM_ADDR_THRESH2: reg_rdata <= second_alarm_threshold;
                `DAM_ADDR_COUNT1:  reg_rdata <= first_alarm_sample_count;
                `DAM_ADDR_COUNT2:  reg_rdata <= second_alarm_sample_count;
                `DAM_ADDR_CTRL:    reg_rdata <= alarm_control;
                `DAM_ADDR_STATUS:  reg_rdata <= {6'h00, alarm_status, 8'h00}; // see (RULE_11)
                default:           reg_rdata <= 16'h0000;
            endcase
        end
    end

    dam_alarm_unit #(.DW(DW)) u_alarm1 (
        .clk          (clk),
        .rst_n        (rst_n),
        .sample_en    (sample_en),
        .src_sel      (alarm_control[`DAM_SRC1_HI:`DAM_SRC1_LO]),
        .slope_mode   (alarm_control[`DAM_SLOPE1_BIT]), // see (RULE_04)
        .threshold    (first_alarm_threshold),
        .sample_count (first_alarm_sample_count[7:0]),
        .sample       (samp1),
        .active       (act1)
    );

    dam_alarm_unit #(.DW(DW)) u_alarm2 (
        .clk          (clk),
        .rst_n        (rst_n),
        .sample_en    (sample_en),
        .src_sel      (alarm_control[`DAM_SRC2_HI:`DAM_SRC2_LO]),
        .slope_mode   (alarm_control[`DAM_SLOPE2_BIT]), // see (RULE_03)
        .threshold    (second_alarm_threshold),
        .sample_count (second_alarm_sample_count[7:0]),
        .sample       (samp2),
        .active       (act2)
    );

    // Outputs registered; one cycle behind the alarm units
    wire any_alarm = act1 | act2; // see (RULE_13)
    wire line_lvl  = alarm_control[`DAM_OUT_POL_BIT] ? any_alarm : ~any_alarm; // see (RULE_07)
    wire out_en    = alarm_control[`DAM_OUT_EN_BIT]; // see (RULE_06)
    wire use_line2 = alarm_control[`DAM_OUT_SEL_BIT]; // see (RULE_08)

    always @(posedge clk) begin
        if (!rst_n) begin
            alarm_status             <= 2'b00;
            first_general_line       <= 1'b0;
            first_general_line_oe_n  <= 1'b1;
            second_general_line      <= 1'b0;
            second_general_line_oe_n <= 1'b1;
        end else begin
            alarm_status             <= {act2, act1}; // see (RULE_11)
            first_general_line       <= line_lvl;
            first_general_line_oe_n  <= ~(out_en & ~use_line2);
            second_general_line      <= line_lvl;
            second_general_line_oe_n <= ~(out_en & use_line2);
        end
    end
endmodule // dam_top

// >>> dv/dam_checker.sv
`timescale 1ns/1ps
module dam_checker (
    input logic        clk,
    input logic        rst_n,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [6:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic [15:0] reg_rdata,
    input logic        first_general_line,
    input logic        first_general_line_oe_n,
    input logic        second_general_line,
    input logic        second_general_line_oe_n,
    input logic [1:0]  alarm_status
);
    logic [15:0] c, c1, c2;
    // Control copy settled for two edges, so output latency never matters
    wire st = c == c1 && c == c2;
    wire en = st && c[2];
    wire ln = c[0] ? second_general_line : first_general_line;
    always @(posedge clk) begin
        c1 <= rst_n ? c : 16'h0000;
        c2 <= rst_n ? c1 : 16'h0000;
        if (!rst_n) c <= 16'h0000;
        else if (reg_wr && reg_addr == 7'h2e) c <= reg_wdata & 16'hffd7;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_off;
        st && !c[2] |-> first_general_line_oe_n && second_general_line_oe_n;
    endproperty
    property p_sel;
        en |-> first_general_line_oe_n == c[0] && second_general_line_oe_n == !c[0];
    endproperty
    property p_pol;
        en |-> ln == ((|alarm_status) ~^ c[1]);
    endproperty
    property p_src1;
        st && c[11:8] == 4'h0 |-> !alarm_status[0];
    endproperty
    property p_src2;
        st && c[15:12] == 4'h0 |-> !alarm_status[1];
    endproperty
    property p_stat;
        reg_rd && reg_addr == 7'h3c |=>
            reg_rdata[9:8] == $past(alarm_status) || reg_rdata[9:8] == alarm_status;
    endproperty
    property p_ctl;
        reg_rd && !reg_wr && reg_addr == 7'h2e |=> reg_rdata == $past(c);
    endproperty
    property p_unm;
        reg_rd && !(reg_addr inside {7'h26, 7'h28, 7'h2a, 7'h2c, 7'h2e, 7'h3c})
            |=> reg_rdata == 16'h0000;
    endproperty
    property p_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_off: assert property (p_off) else $error("line driven");
    a_sel: assert property (p_sel) else $error("wrong line");
    a_pol: assert property (p_pol) else $error("bad level");
    a_src1: assert property (p_src1) else $error("alarm1 on");
    a_src2: assert property (p_src2) else $error("alarm2 on");
    a_stat: assert property (p_stat) else $error("bad status");
    a_ctl: assert property (p_ctl) else $error("bad control");
    a_unm: assert property (p_unm) else $error("unmapped data");
    a_hold: assert property (p_hold) else $error("data moved");
    c_a1: cover property (alarm_status[0] && !first_general_line_oe_n);
    c_a2: cover property (alarm_status[1]);
    c_lo: cover property (en && !c[1] && alarm_status[0]);
    c_both: cover property (&alarm_status);
endmodule // dam_checker
bind dam_top dam_checker chk (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .first_general_line, .first_general_line_oe_n, .second_general_line,
    .second_general_line_oe_n, .alarm_status);

// >>> dv/dam_src_model.sv
`timescale 1ns/1ps
module dam_src_model (
    input  logic         clk,
    output logic         sample_en,
    output logic [167:0] raw_data,
    output logic [167:0] filt_data
);
    initial begin
        sample_en = 1'b0;
        raw_data = '0;
        filt_data = '0;
    end
    // Both banks of a source change together, then one tick, then settle time
    task put(input int k, input logic [13:0] r, input logic [13:0] f);
        @(posedge clk);
        raw_data[k*14 +: 14] <= r;
        filt_data[k*14 +: 14] <= f;
        sample_en <= 1'b1;
        @(posedge clk);
        sample_en <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule // dam_src_model

// >>> dv/dam_top_test.sv
`timescale 1ns/1ps
module dam_top_test;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [6:0]   reg_addr = 7'h00;
    logic [15:0]  reg_wdata = 16'h0000;
    wire  [15:0]  reg_rdata;
    wire  [167:0] raw_data, filt_data;
    wire  [1:0]   alarm_status;
    wire sample_en, first_general_line, first_general_line_oe_n;
    wire second_general_line, second_general_line_oe_n;
    int miscompares = 0, tests_run = 0;
    always #10 clk = ~clk;
    dam_src_model src (.clk, .sample_en, .raw_data, .filt_data);
    dam_top dut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .sample_en, .raw_data, .filt_data, .first_general_line, .first_general_line_oe_n,
        .second_general_line, .second_general_line_oe_n, .alarm_status);
    task give_verdict;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [6:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
    endtask
    // Expected {status, oe2, oe1, level of the driven line}, then status read back
    task obs(input logic [4:0] e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({11'h000, alarm_status, second_general_line_oe_n, first_general_line_oe_n,
            first_general_line_oe_n ? second_general_line : first_general_line}, {11'h000, e});
        rd(7'h3c, {6'h00, e[4:3], 8'h00});
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h2a; a <= 8'h2e; a += 2) rd(a[6:0], 16'h0000);
        wr(7'h30, 16'hffff);
        rd(7'h30, 16'h0000);
        wr(7'h2a, 16'hffff);
        rd(7'h2a, 16'h00ff);
        wr(7'h2e, 16'hffff);
        rd(7'h2e, 16'hffd7);
        wr(7'h26, 16'h8064);
        wr(7'h2e, 16'h0206);
        src.put(2, 14'd200, 14'd0);
        obs(5'b01101);
        wr(7'h2e, 16'h0216);
        src.put(2, 14'd200, 14'd0);
        obs(5'b00100);
        wr(7'h26, 16'h0064);
        src.put(2, 14'd200, 14'h3f9c);
        obs(5'b01101);
        wr(7'h2e, 16'h0215);
        obs(5'b01010);
        wr(7'h2e, 16'h0211);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({14'h0000, second_general_line_oe_n, first_general_line_oe_n}, 16'h0003);
        wr(7'h2e, 16'h0016);
        obs(5'b00100);
        wr(7'h28, 16'h8064);
        src.put(2, 14'd0, 14'd0);
        for (int k = 1; k < 12; k++) begin
            wr(7'h2e, {k[3:0], 12'h006});
            src.put(k, 14'd200, 14'd0);
            obs(5'b10101);
            src.put(k, 14'd0, 14'd0);
        end
        wr(7'h26, 16'h8005);
        wr(7'h2a, 16'h0002);
        wr(7'h2e, 16'h0146);
        src.put(1, 14'd10, 14'd0);
        src.put(1, 14'd20, 14'd0);
        obs(5'b00100);
        src.put(1, 14'd30, 14'd0);
        obs(5'b01101);
        src.put(1, 14'd30, 14'd0);
        src.put(1, 14'd30, 14'd0);
        obs(5'b00100);
        wr(7'h28, 16'h0014);
        wr(7'h2e, 16'h1186);
        src.put(1, 14'd40, 14'd0);
        src.put(1, 14'd50, 14'd0);
        obs(5'b11101);
        give_verdict;
    end
endmodule // dam_top_test
